// >>> adc_slot_sequencer.sv
// Converter slot sequencer with limit checking and register port
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Sixteen shared channels are enabled one by one, eight per block in dual mode.
// - The dedicated channel zero has its own enable bit apart from the shared ones.
// - A temperature conversion paces at 50 kHz, then the rate returns to 1 MHz.
// - A sample above an enabled upper limit raises a violation notice.
// - A sample below an enabled lower limit raises a violation notice.
// - Temperature limits are in degrees Celsius and flag samples above or below.
// - The slot count sets how many entries make one pass of the sequence.
// - A slot can only name an enabled channel; anything else is held empty.
// - An enabled channel named in no slot is never converted.
// - Slots convert in order and wrap from the last back to the first forever.
module adc_slot_sequencer (
  input wire logic MCLK, // System clock, 200 MHz
  input wire logic SYS_RST, // Async reset, high
  input wire logic [9:0] REG_ADDR, // Register byte address
  input wire logic [31:0] REG_WDATA, // Write data
  input wire logic REG_WR, // Write strobe
  input wire logic REG_RD, // Read strobe
  output logic [31:0] REG_RDATA, // Read data, cycle after strobe
  input wire logic PLL_LOCKED, // PLL lock, asynchronous
  output logic CONV_START, // Start one conversion
  output logic [4:0] CONV_CHAN, // Channel to convert
  output logic CONV_TEMP, // Slow temperature rate
  output logic [2:0] CONV_CLK_SEL, // Converter clock selection
  input wire logic CONV_DONE, // Conversion finished
  input wire logic [11:0] CONV_DATA, // Conversion result
  output logic SMP_VALID, // Sample strobe
  output adc_seq_pkg::sample_t SMP_OUT, // Sample with channel
  output logic VIOL_VALID, // Violation strobe
  output adc_seq_pkg::viol_t VIOL_OUT, // Violation flags and channel
  output logic IRQ // Interrupt, level
);
  import adc_seq_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_CONV = 4'b0100,
    ST_CHECK = 4'b1000
  } state_t;

  state_t state_reg;
  logic [2:0] ctrl_reg;
  logic [17:0] chan_en_reg;
  logic [4:0] slot_cnt_reg;
  logic [6:0] clk_freq_reg;
  logic [17:0] hi_en_reg;
  logic [17:0] lo_en_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic [4:0] slot_mem [SLOT_NUM];
  logic [11:0] hi_mem [CH_NUM];
  logic [11:0] lo_mem [CH_NUM];
  logic [3:0] slot_idx_reg;
  logic lock_s1_reg;
  logic lock_s2_reg;
  logic [31:0] rdata_next;
  logic wr_slot;
  logic wr_hi;
  logic wr_lo;
  logic rd_hit;
  logic [4:0] lim_idx;
  logic freq_ok;
  logic go;
  logic fire;
  logic [4:0] slot_ch;
  logic slot_ok;
  logic pace_start;
  logic pace_exp;
  viol_t viol_comb;
  logic [2:0] clk_sel;

  // Wrap after the last configured slot
  function automatic logic [3:0] next_slot(input logic [3:0] idx,
      input logic [4:0] cnt);
    logic [3:0] nxt;
    nxt = 4'h0;
    if ({1'b0, idx} + 5'h01 < cnt)
      nxt = idx + 4'h1;
    return nxt;
  endfunction : next_slot

  assign wr_slot = REG_WR && (REG_ADDR[9:6] == PAGE_SLOT);
  assign wr_hi = REG_WR && (REG_ADDR[9:7] == PAGE_HI);
  assign wr_lo = REG_WR && (REG_ADDR[9:7] == PAGE_LO);
  assign lim_idx = REG_ADDR[6:2];

  // Lock is asynchronous to MCLK
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      lock_s1_reg <= 1'b0;
      lock_s2_reg <= 1'b0;
    end else begin
      lock_s1_reg <= PLL_LOCKED;
      lock_s2_reg <= lock_s1_reg;
    end
  end

  always_comb begin
    clk_sel = 3'h0;
    freq_ok = 1'b1;
    case (clk_freq_reg)
      7'h02: clk_sel = 3'h0;
      7'h0A: clk_sel = 3'h1;
      7'h14: clk_sel = 3'h2;
      7'h28: clk_sel = 3'h3;
      7'h50: clk_sel = 3'h4;
      default: freq_ok = 1'b0;
    endcase
  end

  // Bad clock setting or no lock keeps the sequencer parked
  assign go = ctrl_reg[CTRL_RUN] && lock_s2_reg && freq_ok
              && (slot_cnt_reg != 5'h00);

  // Control registers
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl_reg <= CTRL_RST;
      chan_en_reg <= CHAN_EN_RST;
      slot_cnt_reg <= SLOT_CNT_RST;
      clk_freq_reg <= CLK_FREQ_RST;
      hi_en_reg <= CHAN_EN_RST;
      lo_en_reg <= CHAN_EN_RST;
      irq_mask_reg <= '0;
    end else if (REG_WR) begin
      case (REG_ADDR)
        OFS_CTRL: ctrl_reg <= REG_WDATA[2:0];
        OFS_CHAN_EN: chan_en_reg <= REG_WDATA[17:0];
        OFS_SLOT_CNT: slot_cnt_reg <= (REG_WDATA[4:0] > SLOT_MAX) ?
                                      SLOT_MAX : REG_WDATA[4:0];
        OFS_CLK_FREQ: clk_freq_reg <= REG_WDATA[6:0];
        OFS_HI_EN: hi_en_reg <= REG_WDATA[17:0];
        OFS_LO_EN: lo_en_reg <= REG_WDATA[17:0];
        OFS_IRQ_MASK: irq_mask_reg <= REG_WDATA[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Slot table; a disabled channel is stored as an empty slot
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int i = 0; i < SLOT_NUM; i++)
        slot_mem[i] <= NULL_SLOT;
    end else if (wr_slot) begin
      slot_mem[REG_ADDR[5:2]] <= chan_usable(chan_en_reg, REG_WDATA[4:0],
          ctrl_reg[CTRL_DUAL], ctrl_reg[CTRL_SECOND]) ?
          REG_WDATA[4:0] : NULL_SLOT;
    end
  end

  // Limit tables
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int i = 0; i < CH_NUM; i++) begin
        hi_mem[i] <= HI_LIM_RST;
        lo_mem[i] <= LO_LIM_RST;
      end
    end else if (lim_idx < 5'(CH_NUM)) begin
      if (wr_hi)
        hi_mem[lim_idx] <= REG_WDATA[11:0];
      if (wr_lo)
        lo_mem[lim_idx] <= REG_WDATA[11:0];
    end
  end

  // Slot evaluation at the start of each period
  always_comb begin
    slot_ch = slot_mem[slot_idx_reg];
    slot_ok = chan_usable(chan_en_reg, slot_ch, ctrl_reg[CTRL_DUAL],
                          ctrl_reg[CTRL_SECOND]);
    fire = (state_reg == ST_WAIT) && go && pace_exp;
    pace_start = fire;
  end

  adc_pace_timer u_pace (
    .clk(MCLK),
    .rst(SYS_RST),
    .start(pace_start),
    .slow(slot_ok && (slot_ch == TEMP_CH)),
    .expired(pace_exp)
  );

  // Sequencer state and slot pointer
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg <= ST_IDLE;
      slot_idx_reg <= 4'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (go) begin
            state_reg <= ST_WAIT;
            slot_idx_reg <= 4'h0;
          end
        end
        ST_WAIT: begin
          if (!go)
            state_reg <= ST_IDLE;
          else if (fire && slot_ok)
            state_reg <= ST_CONV;
          else if (fire) // Empty slot still takes its period
            slot_idx_reg <= next_slot(slot_idx_reg, slot_cnt_reg);
        end
        ST_CONV: begin
          // A started conversion is always finished
          if (CONV_DONE)
            state_reg <= ST_CHECK;
        end
        ST_CHECK: begin
          state_reg <= ST_WAIT;
          slot_idx_reg <= next_slot(slot_idx_reg, slot_cnt_reg);
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Converter handshake; only slot contents ever reach it
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      CONV_START <= 1'b0;
      CONV_CHAN <= NULL_SLOT;
      CONV_TEMP <= 1'b0;
      CONV_CLK_SEL <= 3'h0;
    end else begin
      CONV_START <= fire && slot_ok;
      CONV_CLK_SEL <= clk_sel;
      if (fire && slot_ok) begin
        CONV_CHAN <= slot_ch;
        CONV_TEMP <= (slot_ch == TEMP_CH);
      end else if (state_reg == ST_CONV && CONV_DONE) begin
        CONV_TEMP <= 1'b0;
      end
    end
  end

  // Sample capture, tagged with the converted channel
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      SMP_VALID <= 1'b0;
      SMP_OUT <= '0;
    end else begin
      SMP_VALID <= (state_reg == ST_CONV) && CONV_DONE;
      if ((state_reg == ST_CONV) && CONV_DONE) begin
        SMP_OUT.chan <= CONV_CHAN;
        SMP_OUT.data <= CONV_DATA;
      end
    end
  end

  adc_limit_check u_limit (
    .smp(SMP_OUT),
    .hi_en(hi_en_reg[SMP_OUT.chan]),
    .lo_en(lo_en_reg[SMP_OUT.chan]),
    .hi_lim(hi_mem[SMP_OUT.chan]),
    .lo_lim(lo_mem[SMP_OUT.chan]),
    .viol(viol_comb)
  );

  // Violation notice one cycle after the sample
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      VIOL_VALID <= 1'b0;
      VIOL_OUT <= '0;
    end else begin
      VIOL_VALID <= SMP_VALID && (viol_comb.hi || viol_comb.lo);
      if (SMP_VALID)
        VIOL_OUT <= viol_comb;
    end
  end

  // Interrupt status: set wins over a same-cycle clear
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_SAMPLE] = SMP_VALID;
    irq_set[IRQ_HI] = SMP_VALID && viol_comb.hi;
    irq_set[IRQ_LO] = SMP_VALID && viol_comb.lo;
    irq_set[IRQ_SKIP] = fire && !slot_ok;
    irq_clr = (REG_WR && REG_ADDR == OFS_IRQ_STAT) ?
              REG_WDATA[IRQ_W-1:0] : '0;
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_stat_reg <= '0;
      IRQ <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      IRQ <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Read decode
  always_comb begin
    rdata_next = 32'h0000_0000;
    rd_hit = 1'b1;
    case (REG_ADDR)
      OFS_CTRL: rdata_next[2:0] = ctrl_reg;
      OFS_CHAN_EN: rdata_next[17:0] = chan_en_reg;
      OFS_SLOT_CNT: rdata_next[4:0] = slot_cnt_reg;
      OFS_CLK_FREQ: rdata_next[6:0] = clk_freq_reg;
      OFS_STATUS: rdata_next[11:0] = {lock_s2_reg, freq_ok, CONV_TEMP,
                                      state_reg, slot_idx_reg, go};
      OFS_IRQ_STAT: rdata_next[IRQ_W-1:0] = irq_stat_reg;
      OFS_IRQ_MASK: rdata_next[IRQ_W-1:0] = irq_mask_reg;
      OFS_HI_EN: rdata_next[17:0] = hi_en_reg;
      OFS_LO_EN: rdata_next[17:0] = lo_en_reg;
      OFS_LAST: rdata_next[16:0] = SMP_OUT;
      default: rd_hit = 1'b0;
    endcase
    if (!rd_hit) begin
      if (REG_ADDR[9:6] == PAGE_SLOT)
        rdata_next[4:0] = slot_mem[REG_ADDR[5:2]];
      else if (REG_ADDR[9:7] == PAGE_HI && lim_idx < 5'(CH_NUM))
        rdata_next[11:0] = hi_mem[lim_idx];
      else if (REG_ADDR[9:7] == PAGE_LO && lim_idx < 5'(CH_NUM))
        rdata_next[11:0] = lo_mem[lim_idx];
    end
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST)
      REG_RDATA <= 32'h0000_0000;
    else
      REG_RDATA <= REG_RD ? rdata_next : 32'h0000_0000;
  end
endmodule : adc_slot_sequencer
`default_nettype wire

// >>> adc_seq_pkg.sv
// Shared constants, carriers and helpers for the converter slot sequencer
package adc_seq_pkg;
  localparam int DATA_W = 12;
  localparam int CH_W = 5;
  localparam int CH_NUM = 18;
  localparam int SLOT_NUM = 16;
  localparam int IRQ_W = 4;
  localparam logic [4:0] DEDICATED_CH = 5'h00;
  localparam logic [4:0] SHARED_LAST_SINGLE = 5'h10;
  localparam logic [4:0] SHARED_LAST_DUAL = 5'h08;
  localparam logic [4:0] TEMP_CH = 5'h11;
  localparam logic [4:0] NULL_SLOT = 5'h1F;
  localparam logic [4:0] SLOT_MAX = 5'h10;

  // Register offsets, byte addresses on a 10-bit port
  localparam logic [9:0] OFS_CTRL = 10'h000;
  localparam logic [9:0] OFS_CHAN_EN = 10'h004;
  localparam logic [9:0] OFS_SLOT_CNT = 10'h008;
  localparam logic [9:0] OFS_CLK_FREQ = 10'h00C;
  localparam logic [9:0] OFS_STATUS = 10'h010;
  localparam logic [9:0] OFS_IRQ_STAT = 10'h014;
  localparam logic [9:0] OFS_IRQ_MASK = 10'h018;
  localparam logic [9:0] OFS_HI_EN = 10'h01C;
  localparam logic [9:0] OFS_LO_EN = 10'h020;
  localparam logic [9:0] OFS_LAST = 10'h024;
  localparam logic [3:0] PAGE_SLOT = 4'h2;
  localparam logic [2:0] PAGE_HI = 3'h2;
  localparam logic [2:0] PAGE_LO = 3'h3;

  localparam int CTRL_RUN = 0;
  localparam int CTRL_DUAL = 1;
  localparam int CTRL_SECOND = 2;
  localparam int IRQ_SAMPLE = 0;
  localparam int IRQ_HI = 1;
  localparam int IRQ_LO = 2;
  localparam int IRQ_SKIP = 3;

  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [17:0] CHAN_EN_RST = 18'h00000;
  localparam logic [4:0] SLOT_CNT_RST = 5'h00;
  localparam logic [6:0] CLK_FREQ_RST = 7'h50;
  localparam logic [11:0] HI_LIM_RST = 12'hFFF;
  localparam logic [11:0] LO_LIM_RST = 12'h000;

  // Sample pacing at 200 MHz system clock
  localparam int CLK_PERIOD_NS = 5;
  localparam int SAMPLE_NS_FAST = 1000;
  localparam int SAMPLE_NS_TEMP = 20000;
  localparam int CYC_FAST = SAMPLE_NS_FAST / CLK_PERIOD_NS;
  localparam int CYC_TEMP = SAMPLE_NS_TEMP / CLK_PERIOD_NS;

  // Linear raw-to-Celsius map; plain defaults
  localparam logic [11:0] TEMP_ZERO_CODE = 12'h800;
  localparam int TEMP_SHIFT = 3;

  typedef struct packed {
    logic [CH_W-1:0] chan;
    logic [DATA_W-1:0] data;
  } sample_t;

  typedef struct packed {
    logic hi;
    logic lo;
    logic [CH_W-1:0] chan;
  } viol_t;

  function automatic logic chan_usable(input logic [17:0] en,
      input logic [4:0] ch, input logic dual, input logic second);
    logic ok;
    ok = 1'b0;
    if (ch == TEMP_CH)
      ok = en[17] && !(dual && second);
    else if (ch == DEDICATED_CH)
      ok = en[0];
    else if (ch <= (dual ? SHARED_LAST_DUAL : SHARED_LAST_SINGLE))
      ok = en[ch];
    return ok;
  endfunction : chan_usable
endpackage : adc_seq_pkg

// >>> adc_limit_check.sv
// Upper and lower limit comparison for one completed sample
`timescale 1ns/10ps
`default_nettype none
module adc_limit_check (
  input wire adc_seq_pkg::sample_t smp, // Completed sample
  input wire logic hi_en, // Upper limit enabled
  input wire logic lo_en, // Lower limit enabled
  input wire logic [11:0] hi_lim, // Upper limit
  input wire logic [11:0] lo_lim, // Lower limit
  output adc_seq_pkg::viol_t viol // Violation flags
);
  import adc_seq_pkg::*;
  logic temp;
  logic signed [12:0] val;
  logic signed [12:0] hi_v;
  logic signed [12:0] lo_v;
  logic signed [12:0] diff;

  // Temperature limits are signed Celsius, voltages unsigned codes
  always_comb begin
    temp = (smp.chan == TEMP_CH);
    diff = $signed({1'b0, smp.data}) - $signed({1'b0, TEMP_ZERO_CODE});
    val = temp ? (diff >>> TEMP_SHIFT) : $signed({1'b0, smp.data});
    hi_v = temp ? $signed({hi_lim[11], hi_lim}) : $signed({1'b0, hi_lim});
    lo_v = temp ? $signed({lo_lim[11], lo_lim}) : $signed({1'b0, lo_lim});
    viol.chan = smp.chan;
    viol.hi = hi_en && (val > hi_v);
    viol.lo = lo_en && (val < lo_v);
  end
endmodule : adc_limit_check
`default_nettype wire

// >>> adc_pace_timer.sv
// Sample period timer, fast or temperature-slow period
`timescale 1ns/10ps
`default_nettype none
module adc_pace_timer (
  input wire logic clk, // System clock
  input wire logic rst, // Async reset, high
  input wire logic start, // Begin one sample period
  input wire logic slow, // Use temperature period
  output logic expired // Period over
);
  import adc_seq_pkg::*;
  localparam logic [11:0] LOAD_FAST = 12'(CYC_FAST - 1);
  localparam logic [11:0] LOAD_TEMP = 12'(CYC_TEMP - 1);
  logic [11:0] count_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= 12'h000;
      expired <= 1'b1;
    end else if (start) begin
      count_reg <= slow ? LOAD_TEMP : LOAD_FAST;
      expired <= 1'b0;
    end else if (count_reg != 12'h000) begin
      count_reg <= count_reg - 12'h001;
    end else begin
      expired <= 1'b1;
    end
  end
endmodule : adc_pace_timer
`default_nettype wire

// >>> adc_seq_monitor.sv
// Port checker for the converter slot sequencer
`timescale 1ns/10ps
`default_nettype none
module adc_seq_monitor (
  input wire logic MCLK, // Clock
  input wire logic SYS_RST, // Reset
  input wire logic REG_RD, // Read strobe
  input wire logic [31:0] REG_RDATA, // Read data
  input wire logic PLL_LOCKED, // Lock
  input wire logic CONV_START, // Start
  input wire logic [4:0] CONV_CHAN, // Channel
  input wire logic CONV_TEMP, // Slow rate
  input wire logic CONV_DONE, // Done
  input wire logic [11:0] CONV_DATA, // Result
  input wire logic SMP_VALID, // Sample strobe
  input wire adc_seq_pkg::sample_t SMP_OUT, // Sample
  input wire logic VIOL_VALID, // Violation strobe
  input wire adc_seq_pkg::viol_t VIOL_OUT, // Violation
  input wire logic IRQ // Interrupt
);
  import adc_seq_pkg::*;
  logic [11:0] gap_reg;
  logic temp_reg;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  // Saturates so the first start after reset always passes the gap check
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      gap_reg <= 12'hFFF;
    end else if (CONV_START) begin
      gap_reg <= 12'h000;
    end else if (gap_reg != 12'hFFF) begin
      gap_reg <= gap_reg + 12'h001;
    end
  end
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      temp_reg <= 1'b0;
    end else if (CONV_START) begin
      temp_reg <= CONV_TEMP;
    end
  end
  chk_fast_gap: assert property (
    CONV_START && !temp_reg |-> gap_reg >= 12'h0C7) else $error("fast gap");
  chk_slow_gap: assert property (
    CONV_START && temp_reg |-> gap_reg >= 12'hF9F) else $error("slow gap");
  chk_temp_flag: assert property (
    CONV_START |-> CONV_TEMP == (CONV_CHAN == TEMP_CH)) else $error("temp");
  chk_temp_clear: assert property (
    CONV_DONE && CONV_TEMP |=> !CONV_TEMP) else $error("temp clear");
  chk_start_pulse: assert property (
    CONV_START |=> !CONV_START) else $error("start width");
  chk_done_sample: assert property (
    CONV_DONE |=> SMP_VALID && SMP_OUT.data == $past(CONV_DATA)
    && SMP_OUT.chan == $past(CONV_CHAN)) else $error("sample");
  chk_viol_follow: assert property (
    VIOL_VALID |-> $past(SMP_VALID) && VIOL_OUT.chan == $past(SMP_OUT.chan))
    else $error("viol order");
  chk_viol_flag: assert property (
    VIOL_VALID |-> VIOL_OUT.hi || VIOL_OUT.lo) else $error("viol flag");
  chk_lock_hold: assert property (
    !PLL_LOCKED [*4] |-> !CONV_START) else $error("start unlocked");
  chk_rdata_idle: assert property (
    !$past(REG_RD) |-> REG_RDATA == 32'h0) else $error("rdata idle");
  cover property (CONV_START && CONV_TEMP);
  cover property (VIOL_VALID && VIOL_OUT.lo);
  cover property ($rose(IRQ));
endmodule : adc_seq_monitor
bind adc_slot_sequencer adc_seq_monitor mon_u (.MCLK(MCLK), .SYS_RST(SYS_RST),
  .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .PLL_LOCKED(PLL_LOCKED),
  .CONV_START(CONV_START), .CONV_CHAN(CONV_CHAN), .CONV_TEMP(CONV_TEMP),
  .CONV_DONE(CONV_DONE), .CONV_DATA(CONV_DATA), .SMP_VALID(SMP_VALID),
  .SMP_OUT(SMP_OUT), .VIOL_VALID(VIOL_VALID), .VIOL_OUT(VIOL_OUT), .IRQ(IRQ));
`default_nettype wire

// >>> adc_conv_model.sv
// Behavioural converter hard block with adjustable latency
`timescale 1ns/10ps
`default_nettype none
module adc_conv_model (
  input wire logic clk, // Converter clock
  input wire logic rst, // Reset
  input wire logic start, // Start pulse
  input wire logic [11:0] resp, // Result to return
  input wire logic [7:0] lat, // Cycles until done
  output logic done, // Done pulse
  output logic [11:0] data // Result
);
  logic [7:0] cnt_reg;
  logic busy_reg;
  logic [11:0] val_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_reg <= 1'b0;
      cnt_reg <= 8'h00;
      val_reg <= 12'h000;
      done <= 1'b0;
      data <= 12'h000;
    end else begin
      done <= 1'b0;
      // Outside done the bus inverts every cycle and holds no stable result
      data <= ~data;
      if (start) begin
        busy_reg <= 1'b1;
        cnt_reg <= lat;
        val_reg <= resp;
      end else if (busy_reg && cnt_reg == 8'h00) begin
        busy_reg <= 1'b0;
        done <= 1'b1;
        data <= val_reg;
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end
endmodule : adc_conv_model
`default_nettype wire

// >>> adc_slot_sequencer_threshold_tb_top.sv
// Register-driven test of the slot sequencer
`timescale 1ns/10ps
`default_nettype none
module adc_slot_sequencer_threshold_tb_top;
  import adc_seq_pkg::*;
  logic mclk, sys_rst, reg_wr, reg_rd, pll_locked;
  logic [9:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic conv_start, conv_temp, conv_done, smp_valid, viol_valid, irq;
  logic [4:0] conv_chan;
  logic [2:0] conv_clk_sel;
  logic [11:0] conv_data, resp;
  logic [7:0] lat;
  sample_t smp_out;
  viol_t viol_out;
  int mismatches, checked, cycles, n_start, i;
  logic [4:0] seen_chan[$];
  logic [6:0] seen_viol[$];
  logic [6:0] freqs[5] = '{7'h02, 7'h0A, 7'h14, 7'h28, 7'h50};
  logic [4:0] order[3] = '{5'h03, 5'h11, 5'h00};
  logic [6:0] viols[3] = '{7'h43, 7'h51, 7'h20};

  adc_slot_sequencer dut_u (.MCLK(mclk), .SYS_RST(sys_rst),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .PLL_LOCKED(pll_locked),
    .CONV_START(conv_start), .CONV_CHAN(conv_chan), .CONV_TEMP(conv_temp),
    .CONV_CLK_SEL(conv_clk_sel), .CONV_DONE(conv_done),
    .CONV_DATA(conv_data), .SMP_VALID(smp_valid), .SMP_OUT(smp_out),
    .VIOL_VALID(viol_valid), .VIOL_OUT(viol_out), .IRQ(irq));
  adc_conv_model model_u (.clk(mclk), .rst(sys_rst), .start(conv_start),
    .resp(resp), .lat(lat), .done(conv_done), .data(conv_data));

  function automatic logic [11:0] resp_of(input logic [4:0] ch);
    case (ch)
      5'h03: return 12'h180;
      5'h11: return 12'h900;
      default: return 12'h100;
    endcase
  endfunction : resp_of
  assign resp = resp_of(conv_chan);

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge mclk);
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    @(posedge mclk);
    // Strobe taken at this edge; data stand until the next one
    reg_rd <= 1'b0;
    @(posedge mclk);
    check(reg_rdata, e);
  endtask : rd
  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask : idle
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (conv_start) n_start <= n_start + 1;
    if (smp_valid) begin
      seen_chan.push_back(smp_out.chan);
      check(smp_out.data, resp_of(smp_out.chan));
      // Slow answers once the first pass is done
      lat <= (seen_chan.size() > 2) ? 8'h96 : 8'h02;
    end
    if (viol_valid) seen_viol.push_back(viol_out);
    if (cycles == 60000) begin
      mismatches++;
      report_and_stop();
    end
  end

  initial begin
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 10'h000;
    reg_wdata = 32'h0;
    pll_locked = 1'b0;
    lat = 8'h02;
    {mismatches, checked, cycles, n_start} = '0;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    rd(OFS_CLK_FREQ, 32'h50);
    rd(10'h10C, 32'hFFF);
    rd(10'h3FC, 32'h0);
    $display("test reset done");
    for (i = 0; i < 5; i++) begin
      wr(OFS_CLK_FREQ, {25'h0, freqs[i]});
      idle(2);
      check(conv_clk_sel, i);
    end
    // Unsupported clock value reads back with freq_ok clear while the sequencer is idle and not running
    wr(OFS_CLK_FREQ, 32'h3);
    rd(OFS_STATUS, 32'h20);
    wr(OFS_CLK_FREQ, 32'h50);
    $display("test clock select done");
    wr(OFS_CHAN_EN, 32'h21019);
    wr(OFS_CTRL, 32'h6);
    wr(10'h090, 32'hC);
    wr(10'h094, 32'h11);
    wr(OFS_CTRL, 32'h0);
    wr(10'h080, 32'h3);
    wr(10'h084, 32'h5);
    wr(10'h088, 32'h11);
    wr(10'h08C, 32'h0);
    rd(10'h084, 32'h1F);
    rd(10'h090, 32'h1F);
    rd(10'h094, 32'h1F);
    rd(10'h08C, 32'h0);
    wr(OFS_SLOT_CNT, 32'h14);
    rd(OFS_SLOT_CNT, 32'h10);
    wr(OFS_SLOT_CNT, 32'h4);
    wr(10'h10C, 32'h100);
    wr(10'h180, 32'h200);
    wr(10'h144, 32'h14);
    wr(OFS_HI_EN, 32'h20008);
    wr(OFS_LO_EN, 32'h1);
    wr(OFS_IRQ_MASK, 32'h2);
    wr(OFS_CTRL, 32'h1);
    idle(300);
    check(n_start, 0);
    pll_locked <= 1'b1;
    $display("test setup done");
    for (i = 0; i < 15000 && seen_chan.size() < 7; i++) @(posedge mclk);
    check(seen_chan.size(), 7);
    for (i = 0; i < 7; i++) check(seen_chan[i], order[i % 3]);
    check(seen_viol[0], viols[0]);
    check(seen_viol[1], viols[1]);
    check(seen_viol[2], viols[2]);
    $display("test sequence done");
    check(irq, 1'b1);
    rd(OFS_IRQ_STAT, 32'hF);
    wr(OFS_IRQ_MASK, 32'h0);
    idle(3);
    check(irq, 1'b0);
    wr(OFS_CTRL, 32'h0);
    idle(4500);
    wr(OFS_IRQ_MASK, 32'hF);
    wr(OFS_IRQ_STAT, 32'hF);
    idle(3);
    rd(OFS_IRQ_STAT, 32'h0);
    check(irq, 1'b0);
    $display("test interrupt done");
    idle(1);
    report_and_stop();
  end
endmodule : adc_slot_sequencer_threshold_tb_top
`default_nettype wire
